// ==== core/crc_bc4_cfg.svh ====
// Constants for the burst-chop-4 write checksum checker
// Notes on behaviour
// - A2 picks which half carries critical data
// - x4: sixteen real bits, rest tied one
// - A2 high: lane bits land in upper nibble
// - x8: thirty-six real inputs, rest ones
// - A2 low: mask lane in bits 67:64
// - A2 high: mask lane in bits 71:68
// - x16: two identical trees, 36 inputs each
// - x16 A2 low: upper mask in 139:136
// - x16 A2 high: upper mask in 143:140
// - x4: checksum in transfers eight and nine
// - x8: checksum in transfer eight only
// - x16: upper lanes carry checksum high byte
// - Checksum polynomial x^8+x^2+x+1 over 72
// - Start at zero, bit 71 first
// - High byte covers tree inputs 72 to 143
`ifndef CRC_BC4_CFG_SVH
`define CRC_BC4_CFG_SVH

`define CRC_POLY        8'h07
`define CRC_INIT        8'h00
`define TREE_BITS       72
`define LANE_BITS       8
`define DQ_LANES        8
`define X4_LANES        4
`define MASK_LANE       8
`define BC4_BEATS       4
`define CRC_BEAT_LO     4'h8
`define CRC_BEAT_HI     4'h9
`define LAST_DATA_BEAT  4'h3
`define CRITICAL_UPPER  4
`define FIFO_DEPTH      16

`endif

// ==== core/crc_bc4_check.sv ====
// Burst-chop-4 write checksum mapping and check, device side
`timescale 1ns/1ps
`default_nettype none
`include "crc_bc4_cfg.svh"

module crc_bc4_check #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input  wire logic                i_mclk,
    input  wire logic                i_reset_n,
    input  wire logic                i_crc_bc4_en,
    input  wire crc_bc4_pkg::org_t   i_org,
    input  wire logic                i_dm_dbi_en,
    input  wire logic                i_start,
    input  wire logic                i_a2,
    input  wire logic                i_beat_valid,
    input  wire crc_bc4_pkg::beat_t  i_beat,
    output logic                     o_beat_ready,
    output logic                     o_crc_error,
    output logic                     o_frame_done,
    output logic [15:0]              o_crc_calc,
    output logic [15:0]              o_crc_rx,
    output logic                     o_out_valid,
    input  wire logic                i_out_ready,
    output crc_bc4_pkg::result_t     o_out_data
);

    import crc_bc4_pkg::*;

    typedef struct packed {
        phase_t            phase;
        logic [3:0]        beat;
        logic              a2;
        org_t              org;
        logic              mask_use;
        logic [3:0][15:0]  dq;
        logic [3:0][1:0]   mask;
        logic [15:0]       crc_beat8;
        logic              crc_err;
        logic              done;
        logic [15:0]       crc_calc;
        logic [15:0]       crc_rx;
    } chk_st_t;

    // Serial form of the 72-bit tree, first bit is the top one
    function automatic logic [7:0] crc8_tree(input logic [`TREE_BITS-1:0] d);
        logic [7:0] c;
        logic       fb;
        c = `CRC_INIT;
        for (int i = `TREE_BITS - 1; i >= 0; i--) begin
            fb = d[i] ^ c[7];
            c  = {c[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8_tree

    // Places four transfers of one byte group onto tree inputs
    function automatic logic [`TREE_BITS-1:0] map_tree(
        input logic [3:0][7:0] beats,
        input logic [3:0]      mbits,
        input logic            a2,
        input logic            mask_use,
        input logic            x4
    );
        logic [`TREE_BITS-1:0] t;
        int                    base;
        t    = '1;
        base = a2 ? `CRITICAL_UPPER : 0;
        for (int l = 0; l < `DQ_LANES; l++) begin
            for (int b = 0; b < `BC4_BEATS; b++) begin
                if (!x4 || l < `X4_LANES) begin
                    t[`LANE_BITS * l + base + b] = beats[b][l];
                end
            end
        end
        // Mask lane only counts when mask or inversion is on
        for (int b = 0; b < `BC4_BEATS; b++) begin
            t[`LANE_BITS * `MASK_LANE + base + b] = mask_use ? mbits[b] : 1'b1;
        end
        return t;
    endfunction : map_tree

    logic                  rst_meta_reg;
    logic                  rst_sync_reg;
    chk_st_t               st_reg;
    chk_st_t               st_next;
    logic                  fifo_ready;
    logic                  accept;
    logic                  push;
    result_t               push_data;
    logic [3:0][7:0]       lo_beats;
    logic [3:0][7:0]       hi_beats;
    logic [3:0]            lo_mask;
    logic [3:0]            hi_mask;
    logic [`TREE_BITS-1:0] tree_lo;
    logic [`TREE_BITS-1:0] tree_hi;
    logic [7:0]            calc_lo;
    logic [7:0]            calc_hi;
    logic [15:0]           rx_crc;
    logic                  mismatch;

    // Reset is released through two flops
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Full FIFO stalls the whole burst, not just the last beat
    assign o_beat_ready = fifo_ready;
    assign accept       = i_beat_valid && fifo_ready;

    // Split captured transfers into lower and upper byte groups
    always_comb begin
        lo_beats = '0;
        hi_beats = '0;
        lo_mask  = '0;
        hi_mask  = '0;
        for (int b = 0; b < `BC4_BEATS; b++) begin
            lo_beats[b] = st_reg.dq[b][7:0];
            hi_beats[b] = st_reg.dq[b][15:8];
            lo_mask[b]  = st_reg.mask[b][0];
            hi_mask[b]  = st_reg.mask[b][1];
        end
    end

    assign tree_lo = map_tree(lo_beats, lo_mask, st_reg.a2, st_reg.mask_use,
                              st_reg.org == ORG_X4);
    // Second tree is the same logic on the upper group
    assign tree_hi = map_tree(hi_beats, hi_mask, st_reg.a2, st_reg.mask_use,
                              1'b0);
    assign calc_lo = crc8_tree(tree_lo);
    assign calc_hi = crc8_tree(tree_hi);

    // Received checksum, assembled as the organisation places it
    always_comb begin
        rx_crc = '0;
        unique case (st_reg.org)
            ORG_X4: begin
                rx_crc[3:0] = st_reg.crc_beat8[3:0];
                rx_crc[7:4] = i_beat.dq[3:0];
            end
            ORG_X8: begin
                rx_crc[7:0] = st_reg.crc_beat8[7:0];
            end
            ORG_X16: begin
                rx_crc = st_reg.crc_beat8;
            end
            default: begin
                rx_crc = st_reg.crc_beat8;
            end
        endcase
    end

    assign mismatch = (calc_lo != rx_crc[7:0])
                    || ((st_reg.org == ORG_X16) && (calc_hi != rx_crc[15:8]));

    assign push = accept && (st_reg.phase == PH_BURST) && (st_reg.beat == `CRC_BEAT_HI);

    always_comb begin
        push_data         = '0;
        push_data.data    = st_reg.dq;
        push_data.mask    = st_reg.mask;
        push_data.a2      = st_reg.a2;
        push_data.crc_err = mismatch;
    end

    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        st_next.crc_err = 1'b0;
        unique case (st_reg.phase)
            PH_IDLE: begin
                // Only a flagged first transfer opens a burst
                if (accept && i_start && i_crc_bc4_en) begin
                    st_next.phase    = PH_BURST;
                    st_next.beat     = 4'h1;
                    st_next.a2       = i_a2;
                    st_next.org      = i_org;
                    // Narrowest part has no mask lane at all
                    st_next.mask_use = i_dm_dbi_en && (i_org != ORG_X4);
                    st_next.dq       = '1;
                    st_next.mask     = '1;
                    st_next.dq[0]    = i_beat.dq;
                    st_next.mask[0]  = i_beat.mask;
                end
            end
            PH_BURST: begin
                if (accept) begin
                    st_next.beat = st_reg.beat + 4'h1;
                    if (st_reg.beat <= `LAST_DATA_BEAT) begin
                        st_next.dq[st_reg.beat[1:0]]   = i_beat.dq;
                        st_next.mask[st_reg.beat[1:0]] = i_beat.mask;
                    end
                    // Transfers four to seven carry ones and are skipped
                    if (st_reg.beat == `CRC_BEAT_LO) begin
                        st_next.crc_beat8 = i_beat.dq;
                    end
                    if (st_reg.beat == `CRC_BEAT_HI) begin
                        st_next.phase    = PH_IDLE;
                        st_next.beat     = 4'h0;
                        st_next.done     = 1'b1;
                        st_next.crc_err  = mismatch;
                        st_next.crc_calc = {(st_reg.org == ORG_X16) ? calc_hi : 8'h00,
                                            calc_lo};
                        st_next.crc_rx   = rx_crc;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_crc_error  = st_reg.crc_err;
    assign o_frame_done = st_reg.done;
    assign o_crc_calc   = st_reg.crc_calc;
    assign o_crc_rx     = st_reg.crc_rx;

    crc_bc4_fifo #(
        .WIDTH ($bits(result_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_mclk  (i_mclk),
        .i_rst_n (rst_sync_reg),
        .i_valid (push),
        .o_ready (fifo_ready),
        .i_data  (push_data),
        .o_valid (o_out_valid),
        .i_ready (i_out_ready),
        .o_data  (o_out_data)
    );

endmodule : crc_bc4_check

`default_nettype wire

// ==== core/crc_bc4_fifo.sv ====
// Result FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none

module crc_bc4_fifo #(
    parameter int WIDTH = 74,
    parameter int DEPTH = 16
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic [WIDTH-1:0]      o_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW-1:0]    wr;
        logic [AW-1:0]    rd;
        logic [AW:0]      count;
        logic             out_valid;
        logic [WIDTH-1:0] out_data;
    } fifo_st_t;

    localparam logic [AW:0]   FULL_COUNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR   = AW'(DEPTH - 1);

    fifo_st_t         st_reg;
    fifo_st_t         st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             load;

    // Output register holds a result too, so it counts toward capacity
    assign o_ready = (st_reg.count + (AW + 1)'(st_reg.out_valid)) < FULL_COUNT;
    assign o_valid = st_reg.out_valid;
    assign o_data  = st_reg.out_data;
    assign push    = i_valid && o_ready;
    // Output register refills as soon as it empties or drains
    assign load    = (st_reg.count != '0) && (!st_reg.out_valid || i_ready);

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wr = (st_reg.wr == LAST_PTR) ? '0 : st_reg.wr + 1'b1;
        end
        if (load) begin
            st_next.rd        = (st_reg.rd == LAST_PTR) ? '0 : st_reg.rd + 1'b1;
            st_next.out_data  = mem[st_reg.rd];
            st_next.out_valid = 1'b1;
        end else if (i_ready) begin
            st_next.out_valid = 1'b0;
        end
        if (push && !load) begin
            st_next.count = st_reg.count + 1'b1;
        end else if (!push && load) begin
            st_next.count = st_reg.count - 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Storage needs no reset; occupancy guards every read
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[st_reg.wr] <= i_data;
        end
    end

endmodule : crc_bc4_fifo

`default_nettype wire

// ==== core/crc_bc4_pkg.sv ====
// Types shared by the burst-chop-4 write checksum checker
package crc_bc4_pkg;

    typedef enum logic [1:0] {
        ORG_X4,
        ORG_X8,
        ORG_X16
    } org_t;

    typedef enum logic {
        PH_IDLE,
        PH_BURST
    } phase_t;

    // One transfer as sampled from the pins
    typedef struct packed {
        logic [1:0]  mask;
        logic [15:0] dq;
    } beat_t;

    // One checked write, handed on through the FIFO
    typedef struct packed {
        logic                 crc_err;
        logic                 a2;
        logic [3:0][1:0]      mask;
        logic [3:0][15:0]     data;
    } result_t;

endpackage : crc_bc4_pkg

// ==== testbench/crc_bc4_chk.sv ====
// Port checks for the burst-chop-4 checksum checker
`timescale 1ns/1ps
`default_nettype none
module crc_bc4_chk
    import crc_bc4_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic    i_mclk,
    input wire logic    i_reset_n,
    input wire logic    i_crc_bc4_en,
    input wire org_t    i_org,
    input wire logic    i_dm_dbi_en,
    input wire logic    i_start,
    input wire logic    i_a2,
    input wire logic    i_beat_valid,
    input wire beat_t   i_beat,
    input wire logic    o_beat_ready,
    input wire logic    o_crc_error,
    input wire logic    o_frame_done,
    input wire logic [15:0] o_crc_calc,
    input wire logic [15:0] o_crc_rx,
    input wire logic    o_out_valid,
    input wire logic    i_out_ready,
    input wire result_t o_out_data
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    a_done_gap: assert property (o_frame_done |=> !o_frame_done [*8])
        else $error("done pulses too close");
    a_err_done: assert property (o_crc_error |-> o_frame_done)
        else $error("error without done");
    a_err_cmp: assert property (o_frame_done |-> o_crc_error == (o_crc_calc != o_crc_rx))
        else $error("error flag disagrees with checksums");
    a_calc_hold: assert property (!o_frame_done |-> $stable(o_crc_calc))
        else $error("computed checksum moved");
    a_rx_hold: assert property (!o_frame_done |-> $stable(o_crc_rx))
        else $error("received checksum moved");
    a_done_beat: assert property (o_frame_done |-> $past(i_beat_valid && o_beat_ready))
        else $error("done without a last beat");
    a_out_hold: assert property (o_out_valid && !i_out_ready |=>
        o_out_valid && $stable(o_out_data))
        else $error("result head changed while stalled");
    a_out_push: assert property (o_frame_done && !o_out_valid |-> ##[1:2] o_out_valid)
        else $error("result not queued");
    c_err: cover property (o_crc_error);
    c_full: cover property (!o_beat_ready);
    c_stall: cover property (o_out_valid && !i_out_ready);
endmodule : crc_bc4_chk
bind crc_bc4_check crc_bc4_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_crc_bc4_en(i_crc_bc4_en),
    .i_org(i_org), .i_dm_dbi_en(i_dm_dbi_en), .i_start(i_start), .i_a2(i_a2),
    .i_beat_valid(i_beat_valid), .i_beat(i_beat), .o_beat_ready(o_beat_ready),
    .o_crc_error(o_crc_error), .o_frame_done(o_frame_done), .o_crc_calc(o_crc_calc),
    .o_crc_rx(o_crc_rx), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
    .o_out_data(o_out_data));
`default_nettype wire

// ==== testbench/crc_host.sv ====
// Controller model sending burst-chop-4 writes with checksum
`timescale 1ns/1ps
`default_nettype none
module crc_host
    import crc_bc4_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_ready,
    output beat_t     o_beat,
    output logic      o_valid,
    output logic      o_start
);
    initial begin
        o_beat = '0;
        o_valid = 1'b0;
        o_start = 1'b0;
    end
    function automatic logic [7:0] crc8(input logic [71:0] t);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 71; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ (((c[7] ^ t[i]) == 1'b1) ? 8'h07 : 8'h00);
        return c;
    endfunction : crc8
    function automatic logic [15:0] calc(input org_t o, input logic a, input logic dm,
                                         input logic [3:0][15:0] d, input logic [3:0][1:0] m);
        logic [1:0][71:0] t;
        t = '1;
        for (int h = 0; h < 2; h++)
            for (int b = 0; b < 4; b++) begin
                for (int l = 0; l < 8; l++)
                    if (o != ORG_X4 || l < 4)
                        t[h][8*l+b+4*a] = d[b][8*h+l];
                if (o != ORG_X4 && dm)
                    t[h][64+b+4*a] = m[b][h];
            end
        return {(o == ORG_X16) ? crc8(t[1]) : 8'h00, crc8(t[0])};
    endfunction : calc
    task automatic send(input org_t o, input logic a, input logic dm,
                        input logic [3:0][15:0] d, input logic [3:0][1:0] m,
                        input logic bad, input int gap, output logic [15:0] c);
        beat_t bt;
        c = calc(o, a, dm, d, m);
        for (int k = 0; k < 10; k++) begin
            bt = '1;
            if (k < 4)
                bt = {m[k], d[k]};
            if (k == 8)
                bt.dq = (o == ORG_X4) ? {12'hfff, c[3:0]} :
                        {(o == ORG_X16) ? c[15:8] : 8'hff, c[7:0]};
            if (k == 9 && o == ORG_X4)
                bt.dq[3:0] = c[7:4];
            if (k == 8 && bad)
                bt.dq[0] = ~bt.dq[0];
            @(negedge i_clk);
            o_beat = bt;
            o_start = (k == 0);
            o_valid = 1'b1;
            @(posedge i_clk);
            while (!i_ready)
                @(posedge i_clk);
            // Released lines show the inverse so stale data never matches
            if (gap > 0) begin
                @(negedge i_clk);
                o_valid = 1'b0;
                o_beat = ~bt;
                repeat (gap - 1) @(negedge i_clk);
            end
        end
        @(negedge i_clk);
        o_valid = 1'b0;
        o_start = 1'b0;
        o_beat = ~bt;
    endtask : send
endmodule : crc_host
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the burst-chop-4 checksum checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import crc_bc4_pkg::*;
    logic        i_mclk, i_reset_n, en, dm, a2r, out_rdy;
    logic        bvalid, bstart, bready, err, done, ovalid, last_err;
    logic [15:0] calc, rx, last_calc, last_rx;
    org_t        org;
    beat_t       beat;
    result_t     odata;
    result_t     expq[$];
    int          err_count, tests_run, dones, cycles, seq;
    crc_bc4_check #(.FIFO_DEPTH(16)) dut_u (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_crc_bc4_en(en), .i_org(org),
        .i_dm_dbi_en(dm), .i_start(bstart), .i_a2(a2r), .i_beat_valid(bvalid),
        .i_beat(beat), .o_beat_ready(bready), .o_crc_error(err), .o_frame_done(done),
        .o_crc_calc(calc), .o_crc_rx(rx), .o_out_valid(ovalid), .i_out_ready(out_rdy),
        .o_out_data(odata));
    crc_host host_u (.i_clk(i_mclk), .i_ready(bready), .o_beat(beat), .o_valid(bvalid),
                     .o_start(bstart));
    initial i_mclk = 1'b0;
    always #50 i_mclk = ~i_mclk;
    task automatic chk(input string n, input logic [73:0] s, input logic [73:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles > 3000) begin
            err_count++;
            report_and_stop();
        end
        if (done) begin
            dones++;
            last_err = err;
            last_calc = calc;
            last_rx = rx;
        end
        if (ovalid && out_rdy)
            chk("result", odata, (expq.size() > 0) ? expq.pop_front() : '0);
    end
    task automatic wr(input org_t o, input logic a, input logic d, input logic bad, input int gap);
        logic [3:0][15:0] dt;
        logic [3:0][1:0]  mk;
        logic [15:0]      c;
        int               n;
        for (int b = 0; b < 4; b++) begin
            dt[b] = 16'(16'h9e37 * (seq * 4 + b + 1));
            mk[b] = 2'(seq + b);
        end
        seq++;
        @(negedge i_mclk);
        org = o;
        a2r = a;
        dm = d;
        expq.push_back(result_t'({bad, a, mk, dt}));
        n = dones;
        host_u.send(o, a, d, dt, mk, bad, gap, c);
        for (int i = 0; i < 5 && dones == n; i++)
            @(negedge i_mclk);
        chk("done", dones, n + 1);
        chk("error", last_err, bad);
        chk("calc", last_calc, c);
        chk("rx", last_rx, bad ? c ^ 16'h0001 : c);
    endtask : wr
    task automatic s_modes();
        for (int o = 0; o < 3; o++)
            for (int a = 0; a < 2; a++)
                for (int d = 0; d < 2; d++)
                    wr(org_t'(o), 1'(a), 1'(d), 1'b0, 0);
    endtask : s_modes
    task automatic s_bad_slow();
        wr(ORG_X8, 1'b1, 1'b1, 1'b1, 2);
        wr(ORG_X16, 1'b0, 1'b1, 1'b1, 0);
        wr(ORG_X4, 1'b1, 1'b0, 1'b1, 1);
    endtask : s_bad_slow
    task automatic s_off();
        logic [15:0] c;
        int          n;
        n = dones;
        @(negedge i_mclk);
        en = 1'b0;
        host_u.send(ORG_X8, 1'b0, 1'b0, '0, '0, 1'b0, 0, c);
        repeat (4) @(negedge i_mclk);
        chk("disabled", dones, n);
        en = 1'b1;
    endtask : s_off
    task automatic s_fifo();
        @(negedge i_mclk);
        out_rdy = 1'b0;
        for (int i = 0; i < 16; i++)
            wr(ORG_X16, 1'(i), 1'b1, 1'b0, 0);
        @(negedge i_mclk);
        chk("ready_full", bready, 1'b0);
        out_rdy = 1'b1;
        for (int i = 0; i < 60 && expq.size() > 0; i++)
            @(negedge i_mclk);
        chk("drained", expq.size(), 0);
        chk("ready_back", bready, 1'b1);
    endtask : s_fifo
    initial begin
        i_reset_n = 1'b0;
        en = 1'b1;
        dm = 1'b0;
        a2r = 1'b0;
        out_rdy = 1'b1;
        org = ORG_X4;
        repeat (2) @(negedge i_mclk);
        i_reset_n = 1'b1;
        repeat (3) @(negedge i_mclk);
        s_modes();
        s_bad_slow();
        s_off();
        s_fifo();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
